// ### rtl/fpg_port.sv
// Purpose: four pin port, three bidirectional pins and one input pin
// Assumes: stream strobes and neighbour latch come from mclk logic
// Notes: fuse and pin levels are synchronised before use
`default_nettype none
// Function
// - direction 1 floats pin, 0 drives latch
// - analog pin reads zero, input cut
// - bit 7 gates neighbour pull-ups by latch
// - direction bits still steer analog pins
// - reset selects analog on pins 2..0
// - latch register reads latch, not pins
// - fuse 0: pin 3 plain input only
// - fuse 1: pin 3 is master clear
// - bit 3 reads zero under master clear
// - data bits 6..4 read zero
// - small package: only pin 3 exists
// - output path ignores analog selection
// - stream port drives clocks and strobe
// - pin 3 always an input
module fpg_port #(
  parameter bit SMALL_PKG = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [fpg_pkg::ADDR_W-1:0] addr,
  input wire logic [fpg_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [fpg_pkg::DATA_W-1:0] rdata,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe_n,
  input wire logic input_only_pin3,
  input wire logic reset_pin_fuse,
  output logic master_clear_req,
  input wire logic stream_port_enable,
  input wire logic stream_port_clock_one,
  input wire logic stream_port_clock_two,
  input wire logic stream_port_output_strobe,
  input wire logic [7:0] neighbour_latch,
  output logic [7:0] neighbour_pullup
);
  // software state
  logic [2:0] latch;      // output latch
  logic [2:0] pin_direction_bits; // 1 = input
  logic [2:0] analog_sel; // 1 = analog channel on the pin
  logic neighbour_pullup_enable;
  // synchronised outside levels
  logic [2:0] pin_lvl;
  logic pin3_lvl;
  logic fuse_lvl;
  // decoded strobes
  logic wr_data;
  logic wr_latch;
  logic wr_dir;
  logic wr_ansel;
  // read path
  logic [2:0] pin_read;
  logic pin3_read;
  logic [fpg_pkg::DATA_W-1:0] next_rdata;
  logic [2:0] stream_sig;
  logic bidir_on;

  // bidirectional pins exist only in the larger package
  assign bidir_on = ~SMALL_PKG;

  // strobes to the stream port pins, index order 0,1,2
  assign stream_sig = {stream_port_output_strobe, stream_port_clock_two,
                       stream_port_clock_one};

  // pin levels: two flops before anything looks at them
  fpg_sync #(.W(3)) u_sync_pins (
    .mclk(mclk),
    .rst_n(rst_n),
    .d(pin_in),
    .q(pin_lvl)
  );

  // input-only pin and fuse strap share one synchroniser
  fpg_sync #(.W(2)) u_sync_misc (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({reset_pin_fuse, input_only_pin3}),
    .q({fuse_lvl, pin3_lvl})
  );

  // address decode; writes only on an exact offset
  assign wr_data = wr && (addr == fpg_pkg::OFF_DATA);
  assign wr_latch = wr && (addr == fpg_pkg::OFF_LATCH);
  assign wr_dir = wr && (addr == fpg_pkg::OFF_DIR);
  assign wr_ansel = wr && (addr == fpg_pkg::OFF_ANSEL);

  // output latch: written from either the latch or the data offset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch <= fpg_pkg::LATCH_RST;
    end else if (bidir_on && (wr_latch || wr_data)) begin
      latch <= wdata[2:0];
    end
  end

  // direction bits; pin 3 has none at all
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_direction_bits <= fpg_pkg::DIR_RST;
    end else if (bidir_on && wr_dir) begin
      pin_direction_bits <= wdata[2:0];
    end
  end

  // analog select, all channels on after reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      analog_sel <= fpg_pkg::ANSEL_RST;
    end else if (bidir_on && wr_ansel) begin
      analog_sel <= wdata[2:0];
    end
  end

  // neighbour pull-up enable lives in the data register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      neighbour_pullup_enable <= fpg_pkg::PULLUP_RST;
    end else if (bidir_on && wr_data) begin
      neighbour_pullup_enable <= wdata[fpg_pkg::BIT_PULLUP];
    end
  end

  // each pull-up follows its own latch bit while enabled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      neighbour_pullup <= 8'h00;
    end else if (neighbour_pullup_enable) begin
      neighbour_pullup <= neighbour_latch;
    end else begin
      neighbour_pullup <= 8'h00;
    end
  end

  // one cell per bidirectional pin
  for (genvar i = 0; i < fpg_pkg::NBIDIR; i++) begin : g_pin
    fpg_pin_cell u_cell (
      .mclk(mclk),
      .rst_n(rst_n),
      .enable(bidir_on),
      .latch_bit(latch[i]),
      .dir_bit(pin_direction_bits[i]),
      .analog_sel(analog_sel[i]),
      .stream_en(stream_port_enable),
      .stream_sig(stream_sig[i]),
      .pin_lvl(pin_lvl[i]),
      .pin_out(pin_out[i]),
      .pin_oe_n(pin_oe_n[i]),
      .read_bit(pin_read[i])
    );
  end

  // pin 3 is a port input only when the fuse is clear;
  // it never drives, so no driver exists for it
  assign pin3_read = pin3_lvl & ~fuse_lvl;

  // master clear request: pin is active low when the fuse is set
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      master_clear_req <= 1'b0;
    end else begin
      master_clear_req <= fuse_lvl & ~pin3_lvl;
    end
  end

  // read mux; unimplemented bits and unmapped offsets give zero
  always_comb begin
    next_rdata = 8'h00;
    case (addr)
      fpg_pkg::OFF_DATA: begin
        next_rdata[2:0] = pin_read;
        next_rdata[fpg_pkg::BIT_PIN3] = pin3_read;
        next_rdata[fpg_pkg::BIT_PULLUP] = neighbour_pullup_enable;
        // bits 6..4 stay zero
      end
      fpg_pkg::OFF_LATCH: begin
        next_rdata[2:0] = latch;
      end
      fpg_pkg::OFF_DIR: begin
        next_rdata[2:0] = pin_direction_bits;
      end
      fpg_pkg::OFF_ANSEL: begin
        next_rdata[2:0] = analog_sel;
      end
      fpg_pkg::OFF_STATUS: begin
        next_rdata[fpg_pkg::ST_FUSE] = fuse_lvl;
        next_rdata[fpg_pkg::ST_MASTER_CLEAR_INPUT] = master_clear_req;
        next_rdata[fpg_pkg::ST_SMALL] = SMALL_PKG;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  // ---- checks, all on mclk, quiet during reset
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // named steps; the data read step is reused by several checks, the latch steps by one
  sequence s_rd_data;
    rd && (addr == fpg_pkg::OFF_DATA);
  endsequence

  sequence s_wr_latch;
    wr && (addr == fpg_pkg::OFF_LATCH);
  endsequence

  sequence s_rd_latch;
    rd && (addr == fpg_pkg::OFF_LATCH);
  endsequence

  // input direction floats the pin one cycle later
  dir_float_a: assert property (
    (bidir_on && !stream_port_enable && pin_direction_bits[0])
      |=> pin_oe_n[0])
    else $error("pin 0 driven while direction is input");

  // output direction drives the latch, even with analog selected
  drive_latch_a: assert property (
    (bidir_on && !stream_port_enable && !pin_direction_bits[1])
      |=> (!pin_oe_n[1] && pin_out[1] == $past(latch[1])))
    else $error("pin 1 not driving its latch");

  // direction keeps control while the analog channel is on
  analog_dir_a: assert property (
    (bidir_on && !stream_port_enable && analog_sel[2]
      && !pin_direction_bits[2]) |=> !pin_oe_n[2])
    else $error("analog select stopped the pin 2 driver");

  // analog pins read as zero
  analog_zero_a: assert property (
    (s_rd_data and (analog_sel == 3'h7)) |=> (rdata[2:0] == 3'h0))
    else $error("analog pin read as one");

  // pull-ups follow latch only while enabled
  pullup_gate_a: assert property (
    ##1 neighbour_pullup == ($past(neighbour_pullup_enable)
      ? $past(neighbour_latch) : 8'h00))
    else $error("neighbour pull-up mismatch");

  // first cycle out of reset: analog on all three pins
  reset_analog_a: assert property (
    $rose(rst_n) |-> (analog_sel == fpg_pkg::ANSEL_RST))
    else $error("analog select not set after reset");

  // write then read the latch gives back the written value
  latch_back_a: assert property (
    ((s_wr_latch and bidir_on) ##1 (s_rd_latch and !wr))
      |=> (rdata[2:0] == $past(wdata[2:0], 2)))
    else $error("latch read does not return latched value");

  // data offset write lands in the latch
  data_wr_a: assert property (
    (bidir_on && wr && addr == fpg_pkg::OFF_DATA)
      |=> (latch == $past(wdata[2:0])))
    else $error("data write did not set the latch");

  // master clear hides pin 3, unimplemented bits stay zero
  pin3_zero_a: assert property (
    (s_rd_data and fuse_lvl) |=> (rdata[3] == 1'b0))
    else $error("pin 3 visible under master clear");

  unimpl_zero_a: assert property (
    s_rd_data |=> (rdata[6:4] == 3'h0))
    else $error("unimplemented data bits not zero");

  // master clear follows a low pin under a set fuse
  master_clear_input_follow_a: assert property (
    (fuse_lvl && !pin3_lvl) |=> master_clear_req)
    else $error("master clear not raised");

  // stream port drives its strobes out
  // sampled reset keeps the release edge out, drivers are still idle there
  stream_drive_a: assert property (
    (rst_n && bidir_on && stream_port_enable) |=> (pin_oe_n == 3'h0
      && pin_out == $past(stream_sig)))
    else $error("stream strobes not on the pins");

  // small package never drives and never reads the bidir pins
  small_pkg_a: assert property (
    !bidir_on |-> (pin_oe_n == 3'h7 && pin_read == 3'h0))
    else $error("small package exposes bidirectional pins");

  // read data fall back to zero outside the answer cycle
  rdata_idle_a: assert property (
    !rd |=> (rdata == 8'h00))
    else $error("read data stood without a read");

  // pin levels reach the data read, analog pins masked
  pin_read_a: assert property (
    (s_rd_data and bidir_on) |=> (rdata[2:0] == $past(pin_lvl & ~analog_sel)))
    else $error("data read does not show pin levels");

  // input-only pin shows its level while it is a port input
  pin3_read_a: assert property (
    (s_rd_data and !fuse_lvl) |=> (rdata[3] == $past(pin3_lvl)))
    else $error("pin 3 level missing from the data read");

  // master clear drops once the pin is high or the fuse is clear
  master_clear_input_drop_a: assert property (
    !(fuse_lvl && !pin3_lvl) |=> !master_clear_req)
    else $error("master clear held without cause");

  // direction write lands in the direction bits
  dir_wr_a: assert property (
    (bidir_on && wr && addr == fpg_pkg::OFF_DIR)
      |=> (pin_direction_bits == $past(wdata[2:0])))
    else $error("direction write lost");

  // data write also carries the neighbour pull-up enable
  pullup_wr_a: assert property (
    (bidir_on && wr && addr == fpg_pkg::OFF_DATA)
      |=> (neighbour_pullup_enable == $past(wdata[fpg_pkg::BIT_PULLUP])))
    else $error("pull-up enable write lost");

  // small package: software state never leaves its reset values
  small_regs_a: assert property (
    !bidir_on |-> (latch == fpg_pkg::LATCH_RST
      && pin_direction_bits == fpg_pkg::DIR_RST && !neighbour_pullup_enable))
    else $error("small package register changed");

  // status shows the synchronised fuse strap
  status_fuse_a: assert property (
    (rd && addr == fpg_pkg::OFF_STATUS)
      |=> (rdata[fpg_pkg::ST_FUSE] == $past(fuse_lvl)))
    else $error("status does not show the fuse");
endmodule
`default_nettype wire

// ### inc/fpg_pkg.sv
// Purpose: shared constants of the four pin general purpose port
// Assumes: byte wide register port, word index addressing
// Notes: offsets index the plain register port directly
`default_nettype none
package fpg_pkg;
  // register port geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int NBIDIR = 3;
  // register offsets
  localparam logic [2:0] OFF_DATA = 3'h0;   // pin data and pull-up enable
  localparam logic [2:0] OFF_LATCH = 3'h1;  // output latch
  localparam logic [2:0] OFF_DIR = 3'h2;    // pin direction bits
  localparam logic [2:0] OFF_ANSEL = 3'h3;  // analog channel select
  localparam logic [2:0] OFF_STATUS = 3'h4; // read-only strap status
  // field positions in the data register
  localparam int BIT_PULLUP = 7;
  localparam int BIT_PIN3 = 3;
  // field positions in the status register
  localparam int ST_FUSE = 0;
  localparam int ST_MASTER_CLEAR_INPUT = 1;
  localparam int ST_SMALL = 2;
  // reset values
  localparam logic [2:0] DIR_RST = 3'h7;
  localparam logic [2:0] LATCH_RST = 3'h0;
  localparam logic [2:0] ANSEL_RST = 3'h7;
  localparam logic PULLUP_RST = 1'b0;
  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;
endpackage
`default_nettype wire

// ### rtl/fpg_sync.sv
// Purpose: two flip-flop synchroniser for pin level inputs
// Assumes: inputs are slow levels from outside the clock domain
// Notes: first stage feeds only the second stage
`default_nettype none
module fpg_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta; // first stage, may go metastable

  // two stages, reset to zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// ### rtl/fpg_pin_cell.sv
// Purpose: output mux and read path of one bidirectional pin
// Assumes: pin_lvl is already synchronised
// Notes: drive outputs are registered, one cycle after their cause
`default_nettype none
module fpg_pin_cell (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic latch_bit,
  input wire logic dir_bit,
  input wire logic analog_sel,
  input wire logic stream_en,
  input wire logic stream_sig,
  input wire logic pin_lvl,
  output logic pin_out,
  output logic pin_oe_n,
  output logic read_bit
);
  // digital read path is cut when the analog channel owns the pin
  assign read_bit = enable & pin_lvl & ~analog_sel;

  // driver: streaming strobe wins, else latch under direction bit;
  // analog select does not touch the driver, so software must keep dir=1
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
    end else if (!enable) begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
    end else if (stream_en) begin
      pin_out <= stream_sig;
      pin_oe_n <= 1'b0;
    end else begin
      pin_out <= latch_bit;
      pin_oe_n <= dir_bit;
    end
  end
endmodule
`default_nettype wire

// ### dv/fpg_board.sv
// Purpose: board model of the three bidirectional pins
// Assumes: testbench chooses which pins the board drives
// Notes: no pull resistors, so a floating pin toggles every cycle
`default_nettype none
module fpg_board (
  input wire logic mclk,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe_n,
  input wire logic [2:0] drv_en,
  input wire logic [2:0] drv_val,
  output logic [2:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // changing pattern on undriven pins, so a stale value never reads back
  logic [2:0] flip = 3'h5;
  // pattern flips each rising edge
  always @(posedge mclk) begin
    flip <= ~flip;
  end
  // wire level: device driver first, then board, else floating
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!pin_oe_n[i]) begin
        pin_in[i] = pin_out[i];
      end else if (drv_en[i]) begin
        pin_in[i] = drv_val[i];
      end else begin
        pin_in[i] = flip[i];
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/fpg_port_tb.sv
// Purpose: self-checking bench of the four pin port
// Assumes: fixed seed, random register and pin traffic
// Notes: a small-package twin shares every input
`default_nettype none
module fpg_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, rdata_s;
  logic [2:0] pin_in, pin_out, pin_oe_n, drv_en = 3'h0, drv_val = 3'h0;
  logic pin3 = 1'b1;
  logic fuse = 1'b0;
  logic mcr;
  logic st_en = 1'b0;
  logic [2:0] st_sig = 3'h0; // strobe, clock two, clock one
  logic [7:0] nb_lat = 8'h00, nb_pu;
  logic [7:0] v, vs; // last read data of both instances
  logic [7:0] wd; // random data for the latch or data write
  int seed = 32'h9012;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  logic [2:0] lat, dir, an, drive, outv, pins;
  logic pu;
  // 100 ns clock
  initial begin
    forever #50 mclk = ~mclk;
  end
  fpg_port u_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .input_only_pin3(pin3), .reset_pin_fuse(fuse), .master_clear_req(mcr),
    .stream_port_enable(st_en), .stream_port_clock_one(st_sig[0]),
    .stream_port_clock_two(st_sig[1]), .stream_port_output_strobe(st_sig[2]),
    .neighbour_latch(nb_lat), .neighbour_pullup(nb_pu));
  // small package twin, only its read data is judged
  fpg_port #(.SMALL_PKG(1'b1)) u_small (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_s), .pin_in(pin_in), .pin_out(),
    .pin_oe_n(), .input_only_pin3(pin3), .reset_pin_fuse(fuse), .master_clear_req(),
    .stream_port_enable(st_en), .stream_port_clock_one(st_sig[0]),
    .stream_port_clock_two(st_sig[1]), .stream_port_output_strobe(st_sig[2]),
    .neighbour_latch(nb_lat), .neighbour_pullup());
  fpg_board u_board (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .drv_en(drv_en),
    .drv_val(drv_val), .pin_in(pin_in));
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one comparison
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // read strobe, data taken in the following cycle only
  task automatic rd_reg(input logic [2:0] a);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    v = rdata;
    vs = rdata_s;
  endtask
  // let synchronisers and registered drivers settle
  task automatic settle();
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask
  // expected data register read
  function automatic logic [7:0] exp_data(logic [2:0] p, logic [2:0] a, logic f, logic p3,
                                          logic u);
    return {u, 3'h0, p3 & ~f, p & ~a};
  endfunction
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      summarize();
    end
  end
  // main sequence
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    drv_en <= 3'h7;
    drv_val <= 3'h5;
    settle();
    check({5'h0, pin_oe_n}, 8'h07, "reset drivers");
    rd_reg(fpg_pkg::OFF_DIR);
    check(v, {5'h0, fpg_pkg::DIR_RST}, "reset dir");
    rd_reg(fpg_pkg::OFF_ANSEL);
    check(v, 8'h07, "reset analog");
    rd_reg(fpg_pkg::OFF_DATA);
    check(v, 8'h08, "reset data");
    lat = 3'h0;
    pu = 1'b0;
    for (int k = 0; k < 24; k++) begin
      dir = $random(seed);
      an = $random(seed);
      if (k < 12) an = an & dir;
      wr_reg(fpg_pkg::OFF_DIR, {5'h0, dir});
      wr_reg(fpg_pkg::OFF_ANSEL, {5'h0, an});
      // kept off the bus: the write task alone drives wdata, after an edge
      wd = $random(seed);
      lat = wd[2:0];
      if (k[0]) begin
        pu = wd[7];
        wr_reg(fpg_pkg::OFF_DATA, wd);
      end else begin
        wr_reg(fpg_pkg::OFF_LATCH, {5'h0, lat});
      end
      @(posedge mclk);
      st_en <= (k % 4 == 3);
      st_sig <= $random(seed);
      fuse <= $random(seed);
      pin3 <= $random(seed);
      nb_lat <= $random(seed);
      drv_val <= $random(seed);
      drive = (k % 4 == 3) ? 3'h7 : ~dir;
      drv_en <= ~drive;
      settle();
      outv = st_en ? st_sig : lat;
      pins = (drive & outv) | (~drive & drv_val);
      check({5'h0, pin_oe_n}, {5'h0, ~drive}, "drive enable");
      check({5'h0, pin_out & drive}, {5'h0, outv & drive}, "drive value");
      check(nb_pu, pu ? nb_lat : 8'h00, "neighbour pull-ups");
      check({7'h0, mcr}, {7'h0, fuse & ~pin3}, "master clear");
      rd_reg(fpg_pkg::OFF_LATCH);
      check(v, {5'h0, lat}, "latch read");
      rd_reg(fpg_pkg::OFF_DATA);
      check(v, exp_data(pins, an, fuse, pin3, pu), "data read");
      check(vs, {4'h0, pin3 & ~fuse, 3'h0}, "small package");
    end
    // unmapped and read-only places
    wr_reg(3'h4, 8'hff);
    rd_reg(fpg_pkg::OFF_STATUS);
    check(v, {5'h0, 1'b0, fuse & ~pin3, fuse}, "status");
    check(vs, {5'h0, 1'b1, fuse & ~pin3, fuse}, "small status");
    rd_reg(3'h5);
    check(v, 8'h00, "unmapped read");
    // second reset mid-run
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    rd_reg(fpg_pkg::OFF_LATCH);
    check(v, {5'h0, fpg_pkg::LATCH_RST}, "latch after reset");
    rd_reg(fpg_pkg::OFF_ANSEL);
    check(v, {5'h0, fpg_pkg::ANSEL_RST}, "analog after reset");
    summarize();
  end
endmodule
`default_nettype wire
